// file: hbd_defs.svh
// constants for the bridge drive protection controller
`ifndef HBD_DEFS_SVH
`define HBD_DEFS_SVH
// clock and timing
`define HBD_CLK_MHZ      200
`define HBD_CLK_KHZ      200000
`define HBD_DET_NS       500
`define HBD_DET_CYC      ((`HBD_DET_NS * `HBD_CLK_MHZ + 999) / 1000)
`define HBD_HICCUP_MS    112
`define HBD_HICCUP_CYC   (`HBD_HICCUP_MS * `HBD_CLK_MHZ * 1000)
`define HBD_SS_MS        5
`define HBD_SS_CYC       (`HBD_SS_MS * `HBD_CLK_MHZ * 1000)
`define HBD_BBM_NS       4
`define HBD_BBM_CYC      ((`HBD_BBM_NS * `HBD_CLK_MHZ + 999) / 1000)
`define HBD_ILIM_STEPS   255
// switching frequency per setting code, in kHz
`define HBD_FSW0_KHZ     200
`define HBD_FSW1_KHZ     100
`define HBD_FSW2_KHZ     246
`define HBD_FSW3_KHZ     464
`define HBD_FSW4_KHZ     607
`define HBD_FSW5_KHZ     700
`define HBD_FSW6_KHZ     900
`define HBD_FSW7_KHZ     1000
// register offsets
`define HBD_ADDR_CTRL    8'h00
`define HBD_ADDR_STATUS  8'h04
`define HBD_ADDR_ISTAT   8'h08
`define HBD_ADDR_IMASK   8'h0C
// reset values and event bit positions
`define HBD_CTRL_RST     1'h1
`define HBD_IMASK_RST    4'h0
`define HBD_EV_OCP       0
`define HBD_EV_RESTART   1
`define HBD_EV_OT_SET    2
`define HBD_EV_OT_CLR    3
`endif

// file: hbd_pkg.sv
// types for the bridge drive protection controller
package hbd_pkg;
    typedef enum logic [5:0] {
        ST_OFF    = 6'h01,
        ST_DIS    = 6'h02,
        ST_SOFT   = 6'h04,
        ST_RUN    = 6'h08,
        ST_HICCUP = 6'h10,
        ST_THERM  = 6'h20
    } hbd_state_t;

    typedef struct packed {
        logic [1:0]  sg_s;
        logic [1:0]  en_s;
        logic [1:0]  ot_s;
        logic [1:0]  oca_s;
        logic [1:0]  ocb_s;
        logic [1:0]  fpin_s;
        logic [2:0]  fq_s1;
        logic [2:0]  fq_s2;
        hbd_state_t  st;
        logic        en_d;
        logic [10:0] ph_cnt;
        logic        phase;
        logic [7:0]  oc_cnt;
        logic [24:0] hic_cnt;
        logic [19:0] ss_pre;
        logic [7:0]  ilim;
        logic        out_a;
        logic        out_b;
        logic        out_oe;
        logic        fault;
        logic        sw_en;
        logic [3:0]  int_stat;
        logic [3:0]  int_mask;
        logic [31:0] rdata;
    } hbd_regs_t;
endpackage : hbd_pkg

// file: hbd_ctrl.sv
// bridge phase generator with soft start, overcurrent hiccup and thermal shutdown
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "hbd_defs.svh"

module hbd_ctrl #(
    parameter int HICCUP_CYC = `HBD_HICCUP_CYC,
    parameter int SS_CYC     = `HBD_SS_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        supply_good,
    input  wire logic        enable_in,
    input  wire logic        over_temp,
    input  wire logic        ocp_trip_a,
    input  wire logic        ocp_trip_b,
    input  wire logic [2:0]  freq_set_input,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             bridge_out_a,
    output logic             bridge_out_a_oe,
    output logic             bridge_out_b,
    output logic             bridge_out_b_oe,
    input  wire logic        fault_n_i,
    output logic             fault_n_o,
    output logic             fault_n_oe,
    output logic [7:0]       current_limit,
    output logic             irq
);
    import hbd_pkg::*;

    localparam int          DET_LAST = `HBD_DET_CYC - 1;
    localparam int          SS_STEP  = SS_CYC / `HBD_ILIM_STEPS;
    localparam logic [10:0] BBM_CYC  = 11'(`HBD_BBM_CYC);

    // half period in clock cycles for a setting code
    function automatic logic [10:0] half_cyc(input logic [2:0] code);
        int khz;
        unique case (code)
            3'h0: khz = `HBD_FSW0_KHZ;
            3'h1: khz = `HBD_FSW1_KHZ;
            3'h2: khz = `HBD_FSW2_KHZ;
            3'h3: khz = `HBD_FSW3_KHZ;
            3'h4: khz = `HBD_FSW4_KHZ;
            3'h5: khz = `HBD_FSW5_KHZ;
            3'h6: khz = `HBD_FSW6_KHZ;
            3'h7: khz = `HBD_FSW7_KHZ;
        endcase
        return 11'(`HBD_CLK_KHZ / (2 * khz));
    endfunction : half_cyc

    hbd_regs_t   s_r;
    hbd_regs_t   s_nxt;
    logic        en_eff;
    logic        oc_now;
    logic        ot_now;
    logic        sg_now;
    logic [3:0]  ev;
    logic [10:0] half;

    // synchronised pin levels and combined enable
    assign sg_now = s_r.sg_s[1];
    assign ot_now = s_r.ot_s[1];
    assign oc_now = s_r.oca_s[1] | s_r.ocb_s[1];
    assign en_eff = s_r.en_s[1] & s_r.sw_en;
    assign half   = half_cyc(s_r.fq_s2);

    // next state of the whole block
    always_comb begin
        s_nxt = s_r;
        ev    = 4'h0;
        // two-stage synchronisers for all pins except clk_en, rst_n and the register port
        s_nxt.sg_s   = {s_r.sg_s[0], supply_good};
        s_nxt.en_s   = {s_r.en_s[0], enable_in};
        s_nxt.ot_s   = {s_r.ot_s[0], over_temp};
        s_nxt.oca_s  = {s_r.oca_s[0], ocp_trip_a};
        s_nxt.ocb_s  = {s_r.ocb_s[0], ocp_trip_b};
        s_nxt.fpin_s = {s_r.fpin_s[0], fault_n_i};
        s_nxt.fq_s1  = freq_set_input;
        s_nxt.fq_s2  = s_r.fq_s1;
        s_nxt.en_d   = en_eff;

        // mode sequencing
        unique case (s_r.st)
            ST_OFF: begin
                s_nxt.st = en_eff ? ST_SOFT : ST_DIS;
            end
            ST_DIS: begin
                if (en_eff && !s_r.en_d) begin
                    s_nxt.st = ST_SOFT;
                end
            end
            ST_SOFT: begin
                // current limit ramps; overcurrent is not watched here
                if (s_r.ss_pre == 20'(SS_STEP - 1)) begin
                    s_nxt.ss_pre = 20'h00000;
                    if (s_r.ilim == 8'hFF) begin
                        s_nxt.st = ST_RUN;
                    end else begin
                        s_nxt.ilim = s_r.ilim + 8'h01;
                    end
                end else begin
                    s_nxt.ss_pre = s_r.ss_pre + 20'h00001;
                end
            end
            ST_RUN: begin
                if (oc_now) begin
                    if (s_r.oc_cnt == 8'(DET_LAST)) begin
                        s_nxt.st      = ST_HICCUP;
                        s_nxt.hic_cnt = 25'(HICCUP_CYC - 1);
                        ev[`HBD_EV_OCP] = 1'b1;
                    end else begin
                        s_nxt.oc_cnt = s_r.oc_cnt + 8'h01;
                    end
                end else begin
                    s_nxt.oc_cnt = 8'h00;
                end
            end
            ST_HICCUP: begin
                if (s_r.hic_cnt == 25'h0000000) begin
                    s_nxt.st = ST_SOFT;
                    ev[`HBD_EV_RESTART] = 1'b1;
                end else begin
                    s_nxt.hic_cnt = s_r.hic_cnt - 25'h0000001;
                end
            end
            ST_THERM: begin
                if (!ot_now) begin
                    s_nxt.st = en_eff ? ST_SOFT : ST_DIS;
                    ev[`HBD_EV_OT_CLR] = 1'b1;
                end
            end
            default: begin
                s_nxt.st = ST_OFF;
            end
        endcase

        // overrides by priority: supply, temperature, enable
        if (!en_eff && s_r.st != ST_OFF && s_nxt.st != ST_THERM) begin
            s_nxt.st = ST_DIS;
        end
        if (ot_now && s_r.st != ST_OFF) begin
            s_nxt.st = ST_THERM;
            if (s_r.st != ST_THERM) begin
                ev[`HBD_EV_OT_SET] = 1'b1;
            end
        end
        if (!sg_now) begin
            s_nxt.st = ST_OFF;
            ev       = 4'h0;
        end

        // counters are cleared outside the states that use them
        if (s_nxt.st != ST_SOFT && s_nxt.st != ST_RUN) begin
            s_nxt.ss_pre = 20'h00000;
            s_nxt.ilim   = 8'h00;
        end
        if (s_nxt.st == ST_RUN) begin
            s_nxt.ilim = 8'hFF;
        end else begin
            s_nxt.oc_cnt = 8'h00;
        end
        if (s_nxt.st != ST_HICCUP) begin
            s_nxt.hic_cnt = 25'h0000000;
        end

        // phase generator with break-before-make gap
        if ((s_nxt.st == ST_SOFT || s_nxt.st == ST_RUN)
            && (s_r.st == ST_SOFT || s_r.st == ST_RUN)) begin
            if (s_r.ph_cnt >= half - 11'h001) begin
                s_nxt.ph_cnt = 11'h000;
                s_nxt.phase  = ~s_r.phase;
            end else begin
                s_nxt.ph_cnt = s_r.ph_cnt + 11'h001;
            end
        end else begin
            s_nxt.ph_cnt = 11'h000;
            s_nxt.phase  = 1'b0;
        end
        s_nxt.out_oe = (s_nxt.st == ST_SOFT || s_nxt.st == ST_RUN);
        s_nxt.out_a  = s_nxt.out_oe && !s_r.phase && (s_r.ph_cnt >= BBM_CYC);
        s_nxt.out_b  = s_nxt.out_oe && s_r.phase && (s_r.ph_cnt >= BBM_CYC);
        s_nxt.fault  = (s_nxt.st == ST_HICCUP || s_nxt.st == ST_THERM);

        // register writes
        if (reg_wr) begin
            if (reg_addr == `HBD_ADDR_CTRL) begin
                s_nxt.sw_en = reg_wdata[0];
            end
            if (reg_addr == `HBD_ADDR_IMASK) begin
                s_nxt.int_mask = reg_wdata[3:0];
            end
        end

        // sticky events: a read clears, a new event wins
        s_nxt.int_stat = s_r.int_stat | ev;
        if (reg_rd && reg_addr == `HBD_ADDR_ISTAT) begin
            s_nxt.int_stat = ev;
        end

        // read data stand only in the cycle after the strobe
        s_nxt.rdata = 32'h00000000;
        if (reg_rd) begin
            unique case (reg_addr)
                `HBD_ADDR_CTRL:   s_nxt.rdata = {31'h00000000, s_r.sw_en};
                `HBD_ADDR_STATUS: s_nxt.rdata = {16'h0000, s_r.ilim, s_r.fpin_s[1],
                                                 s_r.fault, s_r.st};
                `HBD_ADDR_ISTAT:  s_nxt.rdata = {28'h0000000, s_r.int_stat};
                `HBD_ADDR_IMASK:  s_nxt.rdata = {28'h0000000, s_r.int_mask};
                default:          s_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    // state register, frozen while clock enable is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r          <= '0;
            s_r.st       <= ST_OFF;
            s_r.sw_en    <= `HBD_CTRL_RST;
            s_r.int_mask <= `HBD_IMASK_RST;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign reg_rdata       = s_r.rdata;
    assign bridge_out_a    = s_r.out_a;
    assign bridge_out_a_oe = s_r.out_oe;
    assign bridge_out_b    = s_r.out_b;
    assign bridge_out_b_oe = s_r.out_oe;
    assign fault_n_o       = 1'b0; // open drain: only pulls low
    assign fault_n_oe      = s_r.fault;
    assign current_limit   = s_r.ilim;
    assign irq             = |(s_r.int_stat & s_r.int_mask);

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence live_enabled;
        clk_en && sg_now && !ot_now && en_eff;
    endsequence

    sequence oc_window_end;
        live_enabled ##0 (s_r.st == ST_RUN && oc_now && s_r.oc_cnt == 8'(DET_LAST));
    endsequence

    sequence oc_window_start;
        live_enabled ##0 (s_r.st == ST_RUN && oc_now && s_r.oc_cnt == 8'h00);
    endsequence

    chk_no_supply_idle: assert property (
        clk_en && !sg_now |=> s_r.st == ST_OFF && !bridge_out_a_oe && s_r.hic_cnt == 25'h0000000)
        else $error("switching or timer running without supply good");

    chk_enable_soft_start: assert property (
        live_enabled ##0 (s_r.st == ST_DIS && !s_r.en_d) |=> s_r.st == ST_SOFT && current_limit == 8'h00)
        else $error("enable rise did not start soft start");

    chk_disabled_hiz: assert property (
        clk_en && !en_eff |=> !bridge_out_a_oe && !bridge_out_b_oe)
        else $error("outputs driven while disabled");

    chk_window_then_fault: assert property (
        oc_window_start |-> !fault_n_oe ##1 (!fault_n_oe || !clk_en))
        else $error("fault asserted before the detection window");

    chk_hiccup_entry: assert property (
        oc_window_end |=> s_r.st == ST_HICCUP && !bridge_out_a_oe && !bridge_out_b_oe
                          && s_r.hic_cnt == 25'(HICCUP_CYC - 1))
        else $error("persisting overcurrent did not enter hiccup");

    chk_fault_after_window: assert property (
        oc_window_end |=> fault_n_oe && !fault_n_o)
        else $error("fault not asserted after detection window");

    chk_hiccup_restart: assert property (
        live_enabled ##0 (s_r.st == ST_HICCUP && s_r.hic_cnt == 25'h0000000)
        |=> s_r.st == ST_SOFT && !fault_n_oe && bridge_out_a_oe)
        else $error("hiccup end did not restart and release fault");

    chk_soft_start_blind: assert property (
        live_enabled ##0 (s_r.st == ST_SOFT && s_r.ilim != 8'hFF) |=> s_r.st == ST_SOFT)
        else $error("soft start left early");

    chk_thermal_stop: assert property (
        clk_en && sg_now && ot_now && s_r.st != ST_OFF
        |=> s_r.st == ST_THERM && !bridge_out_a_oe && fault_n_oe)
        else $error("overtemperature did not stop outputs");

    chk_fault_states: assert property (
        fault_n_oe == (s_r.st == ST_HICCUP || s_r.st == ST_THERM))
        else $error("fault output disagrees with protection state");

    chk_default_freq: assert property (
        s_r.fq_s2 == 3'h0 && $stable(s_r.fq_s2) && s_r.st == ST_RUN
        |-> s_r.ph_cnt < half_cyc(3'h0))
        else $error("phase counter beyond default half period");

    chk_break_make: assert property (
        $rose(bridge_out_a) |-> !$past(bridge_out_b) && !bridge_out_b)
        else $error("no gap before phase a turned on");

    chk_phase_exclusive: assert property (
        !(bridge_out_a && bridge_out_b))
        else $error("both bridge phases high together");

    chk_ramp_step: assert property (
        live_enabled ##0 (s_r.st == ST_SOFT && s_r.ilim != 8'hFF
                          && s_r.ss_pre == 20'(SS_STEP - 1))
        |=> current_limit == $past(current_limit) + 8'h01)
        else $error("soft start limit did not step");

    chk_window_restart: assert property (
        live_enabled ##0 (s_r.st == ST_RUN && !oc_now) |=> s_r.oc_cnt == 8'h00 && !fault_n_oe)
        else $error("detection window kept counting after overcurrent gap");

    chk_thermal_release: assert property (
        live_enabled ##0 (s_r.st == ST_THERM) |=> s_r.st == ST_SOFT && !fault_n_oe
                                                 && current_limit == 8'h00)
        else $error("thermal release did not restart soft start");

endmodule : hbd_ctrl

// file: hbd_partner.sv
// far-side model: transformer primary with an overload switch and the pulled-up fault line
`timescale 1ns/1ps
module hbd_partner (
    input  wire logic bridge_out_a,
    input  wire logic bridge_out_a_oe,
    input  wire logic bridge_out_b,
    input  wire logic bridge_out_b_oe,
    input  wire logic fault_n_o,
    input  wire logic fault_n_oe,
    input  wire logic overload,
    output logic      ocp_trip_a,
    output logic      ocp_trip_b,
    output logic      fault_pin
);
    // a low-side switch carries current only while its output is driven low
    assign ocp_trip_a = overload & bridge_out_a_oe & ~bridge_out_a;
    assign ocp_trip_b = overload & bridge_out_b_oe & ~bridge_out_b;
    // open-drain line, pull-up wins when released
    assign fault_pin  = fault_n_oe ? fault_n_o : 1'b1;
endmodule : hbd_partner

// file: test_hbridge_drive_protection_ctrl.sv
// self-checking bench for the bridge drive protection controller
`timescale 1ns/1ps
`include "hbd_defs.svh"
module test_hbridge_drive_protection_ctrl;
    import hbd_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic        clk, rst_n, clk_en, supply_good, enable_in, over_temp, overload;
    logic        ocp_trip_a, ocp_trip_b, fault_pin, reg_wr, reg_rd, irq;
    logic        out_a, out_a_oe, out_b, out_b_oe, fault_n_o, fault_n_oe;
    logic        rd_pend = 1'b0, a_prev = 1'b0, b_prev = 1'b0;
    logic [2:0]  freq_set_input;
    logic [7:0]  reg_addr, current_limit;
    logic [31:0] reg_wdata, reg_rdata;
    logic [31:0] exp_q[$], msk_q[$];
    int          fail_count, total_checks, cyc = 0, per_cnt = 0, per_last = 0;
    int          khz[8] = '{`HBD_FSW0_KHZ, `HBD_FSW1_KHZ, `HBD_FSW2_KHZ, `HBD_FSW3_KHZ,
                            `HBD_FSW4_KHZ, `HBD_FSW5_KHZ, `HBD_FSW6_KHZ, `HBD_FSW7_KHZ};

    hbd_ctrl #(.HICCUP_CYC(200), .SS_CYC(510)) u_hbd_ctrl (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .supply_good(supply_good),
        .enable_in(enable_in), .over_temp(over_temp), .ocp_trip_a(ocp_trip_a),
        .ocp_trip_b(ocp_trip_b), .freq_set_input(freq_set_input), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bridge_out_a(out_a), .bridge_out_a_oe(out_a_oe), .bridge_out_b(out_b),
        .bridge_out_b_oe(out_b_oe), .fault_n_i(fault_pin), .fault_n_o(fault_n_o),
        .fault_n_oe(fault_n_oe), .current_limit(current_limit), .irq(irq));

    hbd_partner u_hbd_partner (
        .bridge_out_a(out_a), .bridge_out_a_oe(out_a_oe), .bridge_out_b(out_b),
        .bridge_out_b_oe(out_b_oe), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
        .overload(overload), .ocp_trip_a(ocp_trip_a), .ocp_trip_b(ocp_trip_b),
        .fault_pin(fault_pin));

    // clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : check_val

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // wait n edges, then look where outputs have settled
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : wait_n

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // read and note the expected answer for the watcher
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        exp_q.push_back(e);
        msk_q.push_back(m);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
    endtask : rd

    // phase watcher, period meter, timeout
    always @(posedge clk) begin
        rd_pend <= reg_rd;
        a_prev  <= out_a;
        b_prev  <= out_b;
        if (out_a && !a_prev) begin
            per_last <= per_cnt;
            per_cnt  <= 1;
        end else begin
            per_cnt  <= per_cnt + 1;
        end
        if ((out_a && !a_prev && b_prev) || (out_b && !b_prev && a_prev))
            check_val("dead_time", 0, 1);
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            check_val("timeout", 0, 1);
            tally_and_finish();
        end
    end

    // read answers stand one cycle after the strobe
    always @(negedge clk) begin
        if (out_a && out_b)
            check_val("overlap", 0, 1);
        if (rd_pend) begin
            check_val("reg_rdata", exp_q[0], reg_rdata & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    initial begin
        logic [31:0] d;
        rst_n = 1'b0;
        clk_en = 1'b1;
        supply_good = 1'b0;
        enable_in = 1'b0;
        over_temp = 1'b0;
        overload = 1'b0;
        freq_set_input = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fail_count = 0;
        total_checks = 0;
        void'($urandom(47));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, unmapped place, ignored write, mask readback
        wait_n(4);
        rd(`HBD_ADDR_CTRL, 32'h1, ALL);
        rd(`HBD_ADDR_IMASK, 32'h0, ALL);
        rd(`HBD_ADDR_ISTAT, 32'h0, ALL);
        wr(`HBD_ADDR_STATUS, ALL);
        rd(8'h10, 32'h0, ALL);
        rd(`HBD_ADDR_STATUS, 32'h81, ALL);
        check_val("oe_idle", 0, out_a_oe | out_b_oe);
        d = $urandom;
        wr(`HBD_ADDR_IMASK, d);
        rd(`HBD_ADDR_IMASK, {28'h0, d[3:0]}, ALL);
        wr(`HBD_ADDR_IMASK, 32'h1);
        $display("test reset_map done");
        // supply good with enable low, then enable rise and soft start
        supply_good <= 1'b1;
        wait_n(10);
        rd(`HBD_ADDR_STATUS, 32'h82, ALL);
        check_val("oe_dis", 0, out_a_oe | out_b_oe);
        @(posedge clk);
        enable_in <= 1'b1;
        wait_n(100);
        rd(`HBD_ADDR_STATUS, 32'h84, 32'hFF);
        check_val("oe_on", 2'b11, {out_a_oe, out_b_oe});
        check_val("ramp", 1, (current_limit > 8'h10) && (current_limit < 8'hFF));
        for (int i = 0; i < 700 && current_limit !== 8'hFF; i++)
            @(posedge clk);
        wait_n(10);
        rd(`HBD_ADDR_STATUS, 32'hFF88, ALL);
        $display("test start done");
        // every frequency code: phase A repeats after two half periods
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            freq_set_input <= 3'(c);
            wait_n(2100 + 6 * (100000 / khz[c]));
            check_val("period", 2 * (100000 / khz[c]), per_last);
        end
        $display("test frequency done");
        // overcurrent: window, hiccup, restart, ignored in soft start, retry
        @(posedge clk);
        overload <= 1'b1;
        wait_n(95);
        check_val("fault_early", 1, fault_pin);
        wait_n(15);
        check_val("fault_oc", 0, fault_pin);
        check_val("oe_hiccup", 0, out_a_oe | out_b_oe);
        check_val("irq_set", 1, irq);
        rd(`HBD_ADDR_STATUS, 32'h50, 32'hFF);
        rd(`HBD_ADDR_ISTAT, 32'h1, ALL);
        wait_n(2);
        check_val("irq_clr", 0, irq);
        wait_n(200);
        check_val("fault_rel", 1, fault_pin);
        rd(`HBD_ADDR_STATUS, 32'h84, 32'hFF);
        check_val("irq_masked", 0, irq);
        rd(`HBD_ADDR_ISTAT, 32'h2, ALL);
        wait_n(300);
        check_val("fault_soft", 1, fault_pin);
        wait_n(350);
        check_val("fault_again", 0, fault_pin);
        @(posedge clk);
        overload <= 1'b0;
        wait_n(250);
        check_val("fault_clear", 1, fault_pin);
        wait_n(600);
        rd(`HBD_ADDR_STATUS, 32'hFF88, ALL);
        check_val("irq_again", 1, irq);
        rd(`HBD_ADDR_ISTAT, 32'h3, ALL);
        $display("test overcurrent done");
        // overtemperature stops the outputs until released
        @(posedge clk);
        over_temp <= 1'b1;
        wait_n(10);
        check_val("oe_hot", 0, out_a_oe | out_b_oe);
        rd(`HBD_ADDR_STATUS, 32'h60, 32'hFF);
        @(posedge clk);
        over_temp <= 1'b0;
        wait_n(10);
        rd(`HBD_ADDR_STATUS, 32'h84, 32'hFF);
        rd(`HBD_ADDR_ISTAT, 32'hC, ALL);
        $display("test thermal done");
        // software disable, re-enable, supply loss
        wait_n(600);
        wr(`HBD_ADDR_CTRL, 32'h0);
        wait_n(6);
        check_val("oe_swdis", 0, out_a_oe | out_b_oe);
        rd(`HBD_ADDR_STATUS, 32'h82, 32'hFF);
        rd(`HBD_ADDR_CTRL, 32'h0, ALL);
        wr(`HBD_ADDR_CTRL, 32'h1);
        wait_n(6);
        rd(`HBD_ADDR_STATUS, 32'h84, 32'hFF);
        // clock enable low freezes the ramp and drops a write
        @(posedge clk);
        clk_en <= 1'b0;
        wait_n(1);
        d = current_limit;
        wr(`HBD_ADDR_IMASK, 32'hF);
        wait_n(20);
        check_val("freeze_limit", d, current_limit);
        check_val("freeze_oe", 2'b11, {out_a_oe, out_b_oe});
        @(posedge clk);
        clk_en <= 1'b1;
        rd(`HBD_ADDR_IMASK, 32'h1, ALL);
        @(posedge clk);
        supply_good <= 1'b0;
        wait_n(6);
        rd(`HBD_ADDR_STATUS, 32'h81, 32'hFF);
        check_val("oe_off", 0, out_a_oe | out_b_oe);
        $display("test disable done");
        tally_and_finish();
    end
endmodule : test_hbridge_drive_protection_ctrl
